// ==== hw/core_exec_defines.svh ====
`ifndef CORE_EXEC_DEFINES_SVH
`define CORE_EXEC_DEFINES_SVH

// instruction word layout
`define INSTR_W          14
`define PC_W             13
`define DATA_W           8
`define FILE_ADDR_W      7
`define FILE_DEPTH       128
`define DEST_BIT         7
`define JUMP_LOW_MSB     10
`define PAGE_HI_BIT      4
`define PAGE_LO_BIT      3

// opcode prefixes
`define OPC_INCREMENT    6'b00_1010
`define OPC_INC_SKIP     6'b00_1111
`define OPC_OR_IMM       6'b11_1000
`define OPC_JUMP         3'b101

// register byte offsets
`define REG_CONTROL      10'h000
`define REG_ACCUM        10'h004
`define REG_PAGE_LATCH   10'h008
`define REG_STATUS       10'h00c
`define REG_FILE_BASE    10'h200
`define CTRL_RUN_BIT     0
`define STAT_NULL_BIT    0
`define STAT_PC_LSB      16

// reset values
`define RST_ACCUM        8'h00
`define RST_PAGE         8'h00
`define RST_PC           13'h0000

// axi responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ==== hw/core_exec_pkg.sv ====
`include "core_exec_defines.svh"

package core_exec_pkg;

  typedef enum {
    OP_NOP,
    OP_INCREMENT,
    OP_INC_SKIP,
    OP_JUMP,
    OP_OR_IMM
  } op_e;

  // program memory fetch port
  typedef struct packed {
    logic [`PC_W-1:0] addr;
  } fetch_req_s;

  typedef struct packed {
    logic [`INSTR_W-1:0] word;
  } fetch_rsp_s;

endpackage : core_exec_pkg

// ==== hw/increment_jump_or_literal_exec.sv ====
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`include "core_exec_defines.svh"

// How it works
// - increment opcode 00 1010 adds one to file register 0..127, updates null flag
// - target bit 0 sends result to accumulator, 1 writes it back to register
// - jump opcode 101 loads 11-bit immediate into program counter bits 10:0
// - jump copies page latch bits 4:3 into counter bits 12:11, flags untouched
// - jump takes two cycles since the already fetched word is dropped
// - increment-skip opcode 00 1111 increments, routes by target bit, flags untouched
// - zero increment-skip result drops the fetched word, a no-op runs instead
// - or-immediate opcode 11 1000 ors accumulator with 8-bit immediate
// - or-immediate result goes to accumulator and updates null flag
module increment_jump_or_literal_exec #(
  parameter int ADDR_W = 10
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  output core_exec_pkg::fetch_req_s      fetch_req,
  input  wire core_exec_pkg::fetch_rsp_s fetch_rsp,
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import core_exec_pkg::*;

  logic [`DATA_W-1:0]  file_mem [`FILE_DEPTH];
  logic [`DATA_W-1:0]  acc_q;
  logic [`DATA_W-1:0]  page_q;
  logic [`PC_W-1:0]    pc_q;
  logic [`INSTR_W-1:0] ir_q;
  logic                ir_valid_q;
  logic                null_q;
  logic                run_q;
  logic [ADDR_W-1:0]   awaddr_q;
  logic                aw_held_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                w_held_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;

  op_e                    op;
  logic [`FILE_ADDR_W-1:0] f_addr;
  logic                   to_file;
  logic [`DATA_W-1:0]     inc_res;
  logic [`DATA_W-1:0]     or_res;
  logic                   inc_zero;
  logic                   do_wr;

  // opcode prefix decode
  function automatic op_e decode_op(input logic [`INSTR_W-1:0] w);
    if (w[13:8] == `OPC_INCREMENT) return OP_INCREMENT;
    if (w[13:8] == `OPC_INC_SKIP) return OP_INC_SKIP;
    if (w[13:8] == `OPC_OR_IMM) return OP_OR_IMM;
    if (w[13:11] == `OPC_JUMP) return OP_JUMP;
    return OP_NOP;
  endfunction : decode_op

  // true when a byte address falls in the file register window
  function automatic logic is_file(input logic [ADDR_W-1:0] a);
    logic [ADDR_W:0] wide; // one spare bit so the window end does not wrap to zero
    wide = {1'b0, a};
    return (wide >= (ADDR_W+1)'(`REG_FILE_BASE)) &&
           (wide < (ADDR_W+1)'(`REG_FILE_BASE + 4 * `FILE_DEPTH));
  endfunction : is_file

  // execute stage decode and datapath
  always_comb begin
    op       = (run_q && ir_valid_q) ? decode_op(ir_q) : OP_NOP;
    f_addr   = ir_q[`FILE_ADDR_W-1:0];
    to_file  = ir_q[`DEST_BIT];
    inc_res  = file_mem[f_addr] + 8'h01;
    or_res   = acc_q | ir_q[`DATA_W-1:0];
    inc_zero = (inc_res == 8'h00);
  end

  assign fetch_req.addr = pc_q;

  // program counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= `RST_PC;
    end else if (run_q) begin
      if (op == OP_JUMP) begin
        pc_q <= {page_q[`PAGE_HI_BIT:`PAGE_LO_BIT], ir_q[`JUMP_LOW_MSB:0]};
      end else begin
        pc_q <= pc_q + 13'h0001;
      end
    end
  end

  // fetched word register, flushed on jump or taken skip
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_q       <= '0;
      ir_valid_q <= 1'b0;
    end else if (run_q) begin
      ir_q <= fetch_rsp.word;
      if (op == OP_JUMP) begin
        ir_valid_q <= 1'b0;
      end else if (op == OP_INC_SKIP && inc_zero) begin
        ir_valid_q <= 1'b0;
      end else begin
        ir_valid_q <= 1'b1;
      end
    end else begin
      ir_valid_q <= 1'b0;
    end
  end

  // result null flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      null_q <= 1'b0;
    end else if (op == OP_INCREMENT) begin
      null_q <= inc_zero;
    end else if (op == OP_OR_IMM) begin
      null_q <= (or_res == 8'h00);
    end
  end

  assign do_wr = aw_held_q && w_held_q && !bvalid_q;

  // accumulator, core result wins over a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= `RST_ACCUM;
    end else if ((op == OP_INCREMENT || op == OP_INC_SKIP) && !to_file) begin
      acc_q <= inc_res;
    end else if (op == OP_OR_IMM) begin
      acc_q <= or_res;
    end else if (do_wr && awaddr_q == `REG_ACCUM && wstrb_q[0]) begin
      acc_q <= wdata_q[7:0];
    end
  end

  // file registers, core result wins over a software write
  always_ff @(posedge aclk) begin
    if ((op == OP_INCREMENT || op == OP_INC_SKIP) && to_file) begin
      file_mem[f_addr] <= inc_res;
    end else if (do_wr && is_file(awaddr_q) && wstrb_q[0]) begin
      file_mem[awaddr_q[8:2]] <= wdata_q[7:0];
    end
  end

  // control and page latch registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q  <= 1'b0;
      page_q <= `RST_PAGE;
    end else if (do_wr && wstrb_q[0]) begin
      if (awaddr_q == `REG_CONTROL) begin
        run_q <= wdata_q[`CTRL_RUN_BIT];
      end
      if (awaddr_q == `REG_PAGE_LATCH) begin
        page_q <= wdata_q[7:0];
      end
    end
  end

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_wr) begin
        w_held_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (awaddr_q == `REG_CONTROL || awaddr_q == `REG_ACCUM ||
                   awaddr_q == `REG_PAGE_LATCH || is_file(awaddr_q)) ?
                  `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // read channel, data registered one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `RESP_OKAY;
      if (s_axi_araddr == `REG_CONTROL) begin
        rdata_q <= {31'h0, run_q};
      end else if (s_axi_araddr == `REG_ACCUM) begin
        rdata_q <= {24'h0, acc_q};
      end else if (s_axi_araddr == `REG_PAGE_LATCH) begin
        rdata_q <= {24'h0, page_q};
      end else if (s_axi_araddr == `REG_STATUS) begin
        rdata_q <= {3'h0, pc_q, 15'h0, null_q};
      end else if (is_file(s_axi_araddr)) begin
        rdata_q <= {24'h0, file_mem[s_axi_araddr[8:2]]};
      end else begin
        rdata_q <= '0;
        rresp_q <= `RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : increment_jump_or_literal_exec

// ==== verification/exec_sva.sv ====
module exec_sva #(
  parameter int ADDR_W = 10
) (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire core_exec_pkg::fetch_req_s fetch_req,
  input wire core_exec_pkg::fetch_rsp_s fetch_rsp,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  import core_exec_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // counter leaves sequence only for a jump target taken two words back
  pc_jump_a: assert property (fetch_req.addr != $past(fetch_req.addr)
    && fetch_req.addr != $past(fetch_req.addr) + 13'h1
    |-> $past(fetch_rsp.word[13:11], 2) == 3'b101
    && fetch_req.addr[10:0] == $past(fetch_rsp.word[10:0], 2)) else $error("pc jump wrong");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
endmodule : exec_sva

bind increment_jump_or_literal_exec exec_sva #(.ADDR_W(ADDR_W)) exec_sva_i (.aclk, .aresetn,
  .fetch_req, .fetch_rsp, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready);

// ==== verification/prog_mem.sv ====
module prog_mem (
  input  wire core_exec_pkg::fetch_req_s req,
  output core_exec_pkg::fetch_rsp_s      rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] mem [8192];
  // combinational read, unloaded words hold no-op
  assign rsp.word = mem[req.addr];
  initial begin
    foreach (mem[i]) mem[i] = 14'h0000;
  end
endmodule : prog_mem

// ==== verification/tb_increment_jump_or_literal_exec.sv ====
`include "core_exec_defines.svh"
module tb_increment_jump_or_literal_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import core_exec_pkg::*;
  logic aclk = 0, aresetn = 0;
  fetch_req_s fetch_req;
  fetch_rsp_s fetch_rsp;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int mismatches = 0, n_checks = 0;
  prog_mem prog_mem_i (.req(fetch_req), .rsp(fetch_rsp));
  increment_jump_or_literal_exec increment_jump_or_literal_exec_i (.aclk, .aresetn, .fetch_req,
    .fetch_rsp, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial begin
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // write cycle, address and data offered together
  task automatic wr(input logic [9:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] r);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk(s_axi_bresp, r);
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [1:0] r, output logic [31:0] v);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    v = s_axi_rdata;
    chk(s_axi_rresp, r);
    @(posedge aclk);
  endtask : rd
  // reset values, refused places, masked write
  task automatic t_regs;
    rd(`REG_ACCUM, `RESP_OKAY, d); chk(d, 0);
    rd(`REG_STATUS, `RESP_OKAY, d); chk(d, 0);
    wr(`REG_STATUS, 1, 4'hf, `RESP_SLVERR);
    wr(10'h100, 1, 4'hf, `RESP_SLVERR);
    rd(10'h100, `RESP_SLVERR, d); chk(d, 0);
    wr(`REG_ACCUM, 8'h55, 4'h0, `RESP_OKAY);
    rd(`REG_ACCUM, `RESP_OKAY, d); chk(d, 0);
  endtask : t_regs
  // program with or, increments, skip, jump to upper page
  task automatic t_prog;
    logic [13:0] p [8] = '{14'h3835, 14'h0a82, 14'h0a01, 14'h0f83, 14'h3880, 14'h0f04,
                           14'h2ff0, 14'h3840};
    logic [7:0] f [5] = '{8'h00, 8'hff, 8'h10, 8'hff, 8'h05};
    foreach (p[i]) prog_mem_i.mem[i] = p[i];
    prog_mem_i.mem[13'h1ff0] = 14'h2ff0;
    for (int i = 1; i < 5; i++) wr(`REG_FILE_BASE + 10'(4 * i), f[i], 4'h1, `RESP_OKAY);
    wr(`REG_PAGE_LATCH, 8'h18, 4'h1, `RESP_OKAY);
    wr(`REG_CONTROL, 1, 4'h1, `RESP_OKAY);
    repeat (20) @(posedge aclk);
    wr(`REG_CONTROL, 0, 4'h1, `RESP_OKAY);
    rd(`REG_ACCUM, `RESP_OKAY, d); chk(d, 8'h06);
    rd(`REG_FILE_BASE + 10'h008, `RESP_OKAY, d); chk(d, 8'h11);
    rd(`REG_FILE_BASE + 10'h00c, `RESP_OKAY, d); chk(d, 8'h00);
    rd(`REG_FILE_BASE + 10'h010, `RESP_OKAY, d); chk(d, 8'h05);
    rd(`REG_STATUS, `RESP_OKAY, d); chk(d & 32'h1ff00001, 32'h1ff00001);
  endtask : t_prog
  // reset while the core is stopped, then or-immediate sets and clears the null flag
  task automatic t_null;
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`REG_ACCUM, `RESP_OKAY, d); chk(d, 0);
    rd(`REG_STATUS, `RESP_OKAY, d); chk(d, 0);
    prog_mem_i.mem[0] = 14'h3800;
    prog_mem_i.mem[1] = 14'h2801;
    wr(`REG_CONTROL, 1, 4'h1, `RESP_OKAY);
    repeat (20) @(posedge aclk);
    wr(`REG_CONTROL, 0, 4'h1, `RESP_OKAY);
    rd(`REG_ACCUM, `RESP_OKAY, d); chk(d, 8'h00);
    rd(`REG_STATUS, `RESP_OKAY, d); chk(d & 32'h1ffc0001, 32'h00000001);
    prog_mem_i.mem[1] = 14'h3881;
    prog_mem_i.mem[2] = 14'h3881;
    prog_mem_i.mem[3] = 14'h2803;
    wr(`REG_CONTROL, 1, 4'h1, `RESP_OKAY);
    repeat (20) @(posedge aclk);
    wr(`REG_CONTROL, 0, 4'h1, `RESP_OKAY);
    rd(`REG_ACCUM, `RESP_OKAY, d); chk(d, 8'h81);
    rd(`REG_STATUS, `RESP_OKAY, d); chk(d & 32'h1ff80001, 32'h00000000);
  endtask : t_null
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  initial begin
    #100us;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs();
    t_prog();
    t_null();
    test_done();
  end
endmodule : tb_increment_jump_or_literal_exec
